// ===== smsp_defs.vh
// Register map, field layout and timing constants of the serial port
`ifndef SMSP_DEFS_VH
`define SMSP_DEFS_VH

// Register offsets
`define SMSP_ADDR_DATA      8'h60
`define SMSP_ADDR_CTRL      8'h61

// Control register reset value
`define SMSP_CTRL_RESET     8'h00

// Control register field positions
`define SMSP_BIT_DONE       7
`define SMSP_BIT_TBF        6
`define SMSP_MODE_HI        5
`define SMSP_MODE_LO        4
`define SMSP_BIT_CLOCK_POLARITY_BIT       3
`define SMSP_BIT_CLOCK_PHASE_BIT       2
`define SMSP_RATE_HI        1
`define SMSP_RATE_LO        0

// Function select codes
`define SMSP_MODE_OFF       2'b00
`define SMSP_MODE_MASTER    2'b01
`define SMSP_MODE_SLAVE     2'b10

// Master bit periods in ns for rate codes 00..11 (2, 1, 0.5, 0.0625 Mbit/s)
`define SMSP_BIT_NS_0       500
`define SMSP_BIT_NS_1       1000
`define SMSP_BIT_NS_2       2000
`define SMSP_BIT_NS_3       16000

// Reference clock rate in MHz
`define SMSP_CLK_MHZ        10

// Bits per transfer
`define SMSP_LAST_BIT       3'd7

`endif

// ===== smsp_core.v
// Byte-serial SPI port, master or slave, with control register and pin bypass drive
// Timing notes
// Every pin passes two flip-flops, so slave edges show three clocks late.
// Master outputs leave through the bypass flops one clock after the shifter.
// Master read data come back through the pin synchroniser, a round trip
// longer than the low half at the fastest rate; with phase zero the master
// therefore takes its bit at the trailing edge, where it is still stable.
// The slave delays its data and clock pins alike, so it takes its bit at
// the edge that the phase bit names.
// The fastest rate runs near a 40/60 duty; the others run at half.
// Reserved mode 11 behaves as disabled and leaves every bypass at one.
// The interrupt is a one-clock pulse; the done flag is its sticky copy.
// A slave with no byte loaded shifts out whatever the shifter holds.
// Leaving an active mode drops any byte in flight without an interrupt.
// Limitation: the far side must hold each link clock level for longer than
// one reference clock, or the slave misses the edge.
`timescale 1ns/1ps
`default_nettype none
`include "smsp_defs.vh"

module smsp_core #(
  parameter CLK_MHZ = `SMSP_CLK_MHZ
) (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       resetn,
  // Register port
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata_q,
  // Byte-complete interrupt request
  output reg        spi_irq_q,
  // Port zero pin levels
  input  wire       port_zero_line_four_in,
  input  wire       port_zero_line_five_in,
  input  wire       port_zero_line_six_in,
  input  wire       port_zero_line_seven_in,
  // Port zero bypass values
  output reg        port_zero_line_four_bypass_q,
  output reg        port_zero_line_five_bypass_q,
  output reg        port_zero_line_six_bypass_q,
  output reg        port_zero_line_seven_bypass_q
);

  // Half-bit length in reference clocks; second half takes the odd cycle,
  // so the fastest rate runs near a 40/60 duty rather than exactly half
  function [7:0] half_cycles;
    input [1:0] code;
    input       second;
    reg   [31:0] bit_cyc;
    reg   [31:0] half;
    begin
      case (code)
        2'b00:   bit_cyc = (`SMSP_BIT_NS_0 * CLK_MHZ) / 1000;
        2'b01:   bit_cyc = (`SMSP_BIT_NS_1 * CLK_MHZ) / 1000;
        2'b10:   bit_cyc = (`SMSP_BIT_NS_2 * CLK_MHZ) / 1000;
        default: bit_cyc = (`SMSP_BIT_NS_3 * CLK_MHZ) / 1000;
      endcase
      half = second ? (bit_cyc - (bit_cyc >> 1)) : (bit_cyc >> 1);
      if (half == 32'd0) begin
        half = 32'd1;
      end
      half_cycles = half[7:0];
    end
  endfunction

  // Exact byte-address match, shared by both strobes
  function addr_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // Control fields
  reg  [1:0] mode_q;
  reg        clock_polarity_bit_q;
  reg        clock_phase_bit_q;
  reg  [1:0] rate_q;
  reg        done_flag_q;
  reg        tbf_q;

  // Data path
  reg  [7:0] tx_q;
  reg  [7:0] rx_q;
  reg  [7:0] shift_q;
  reg        rx_bit_q;
  reg  [2:0] bit_cnt_q;

  // Master clock generator
  reg        busy_q;
  reg        phase_q;
  reg        sck_act_q;
  reg  [7:0] timer_q;

  // Pin synchronisers: index 0 select, 1 line five, 2 line six, 3 clock
  reg  [3:0] sync1_q;
  reg  [3:0] sync2_q;
  reg        sck_prev_q;

  wire       is_master;
  wire       is_slave;
  wire       ss_low;
  wire       sck_now;
  wire       in_bit;
  wire       m_tick;
  wire       lead_ev;
  wire       trail_ev;
  wire       load_ev;
  wire       done_ev;
  wire [7:0] next_byte;
  wire       wr_data;
  wire       wr_ctrl;
  wire       take_pin;

  // Register read decode
  wire       rd_data;
  wire       rd_ctrl;
  wire [7:0] ctrl_word;

  assign is_master = (mode_q == `SMSP_MODE_MASTER);
  assign is_slave  = (mode_q == `SMSP_MODE_SLAVE);
  assign ss_low    = ~sync2_q[0];
  assign sck_now   = sync2_q[3];
  assign in_bit    = is_master ? sync2_q[2] : sync2_q[1];
  assign wr_data   = reg_wr && addr_hit(reg_addr, `SMSP_ADDR_DATA);
  assign wr_ctrl   = reg_wr && addr_hit(reg_addr, `SMSP_ADDR_CTRL);
  assign rd_data   = reg_rd && addr_hit(reg_addr, `SMSP_ADDR_DATA);
  assign rd_ctrl   = reg_rd && addr_hit(reg_addr, `SMSP_ADDR_CTRL);
  assign ctrl_word = {done_flag_q, tbf_q, mode_q, clock_polarity_bit_q, clock_phase_bit_q, rate_q};

  // Master edges come from the timer; slave edges from the synced clock pin
  assign m_tick   = is_master && busy_q && (timer_q == 8'h01);
  assign lead_ev  = m_tick ? ~phase_q :
                    (is_slave && ss_low && (sck_prev_q == clock_polarity_bit_q) && (sck_now != clock_polarity_bit_q));
  assign trail_ev = m_tick ? phase_q :
                    (is_slave && ss_low && (sck_prev_q != clock_polarity_bit_q) && (sck_now == clock_polarity_bit_q));

  // Shifter takes the waiting byte only between bytes
  assign load_ev = tbf_q && (bit_cnt_q == 3'd0) &&
                   ((is_master && !busy_q) ||
                    (is_slave && ss_low && !lead_ev && !trail_ev));

  // With phase one the last bit is taken straight from the pin; the master
  // always takes it at the trailing edge, since its pin round trip is longer
  // than the fastest low half
  assign take_pin  = clock_phase_bit_q || is_master;
  assign next_byte = {shift_q[6:0], (take_pin ? in_bit : rx_bit_q)};
  assign done_ev   = trail_ev && (bit_cnt_q == `SMSP_LAST_BIT);

  // Two-stage synchronisers for all pins, plus one stage for edge finding;
  // select resets high so the slave starts deselected
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q    <= 4'hf;
      sync2_q    <= 4'hf;
      sck_prev_q <= 1'b0;
    end else begin
      sync1_q    <= {port_zero_line_seven_in, port_zero_line_six_in,
                     port_zero_line_five_in, port_zero_line_four_in};
      sync2_q    <= sync1_q;
      sck_prev_q <= sync2_q[3];
    end
  end

  // Control register and transmit buffer
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mode_q      <= 2'b00;
      clock_polarity_bit_q      <= 1'b0;
      clock_phase_bit_q      <= 1'b0;
      rate_q      <= 2'b00;
      done_flag_q <= 1'b0;
      tbf_q       <= 1'b0;
      tx_q        <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        mode_q <= reg_wdata[`SMSP_MODE_HI:`SMSP_MODE_LO];
        clock_polarity_bit_q <= reg_wdata[`SMSP_BIT_CLOCK_POLARITY_BIT];
        clock_phase_bit_q <= reg_wdata[`SMSP_BIT_CLOCK_PHASE_BIT];
        rate_q <= reg_wdata[`SMSP_RATE_HI:`SMSP_RATE_LO];
      end

      // A completion in the same cycle as a clearing write wins
      if (done_ev) begin
        done_flag_q <= 1'b1;
      end else if (wr_ctrl && !reg_wdata[`SMSP_BIT_DONE]) begin
        done_flag_q <= 1'b0;
      end

      // A write during a load keeps the flag set for the new byte
      if (wr_data) begin
        tx_q  <= reg_wdata;
        tbf_q <= 1'b1;
      end else if (load_ev) begin
        tbf_q <= 1'b0;
      end
    end
  end

  // Shift engine and master clock generator
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      shift_q   <= 8'h00;
      rx_bit_q  <= 1'b0;
      bit_cnt_q <= 3'd0;
      busy_q    <= 1'b0;
      phase_q   <= 1'b0;
      sck_act_q <= 1'b0;
      timer_q   <= 8'h01;
    end else if (!is_master && !is_slave) begin
      // Leaving the active modes drops any byte in flight
      bit_cnt_q <= 3'd0;
      busy_q    <= 1'b0;
      phase_q   <= 1'b0;
      sck_act_q <= 1'b0;
    end else if (is_slave && !ss_low) begin
      // The done flag is left as it was
      bit_cnt_q <= 3'd0;
      busy_q    <= 1'b0;
      sck_act_q <= 1'b0;
    end else begin
      if (load_ev) begin
        shift_q   <= tx_q;
        busy_q    <= is_master;
        phase_q   <= 1'b0;
        sck_act_q <= 1'b0;
        timer_q   <= half_cycles(rate_q, 1'b0);
      end
      if (lead_ev) begin
        if (!clock_phase_bit_q) begin
          rx_bit_q <= in_bit;
        end else if (bit_cnt_q != 3'd0) begin
          shift_q <= {shift_q[6:0], rx_bit_q};
        end
        if (is_master) begin
          sck_act_q <= 1'b1;
          phase_q   <= 1'b1;
          timer_q   <= half_cycles(rate_q, 1'b1);
        end
      end else if (trail_ev) begin
        if (clock_phase_bit_q) begin
          rx_bit_q <= in_bit;
        end else begin
          shift_q <= next_byte;
        end
        bit_cnt_q <= bit_cnt_q + 3'd1;
        if (is_master) begin
          sck_act_q <= 1'b0;
          phase_q   <= 1'b0;
          timer_q   <= half_cycles(rate_q, 1'b0);
        end
        if (done_ev) begin
          busy_q <= 1'b0;
        end
      end else if (is_master && busy_q && !load_ev) begin
        // Count down to one; each tick reloads the other half
        timer_q <= timer_q - 8'h01;
      end
    end
  end

  // Receive buffer and interrupt pulse
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_q      <= 8'h00;
      spi_irq_q <= 1'b0;
    end else begin
      if (done_ev) begin
        rx_q <= next_byte;
      end
      spi_irq_q <= done_ev;
    end
  end

  // Read data stand for one cycle only; unmapped reads return zero
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_q <= 8'h00;
    end else if (rd_data) begin
      reg_rdata_q <= rx_q;
    end else if (rd_ctrl) begin
      reg_rdata_q <= ctrl_word;
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  // Bypass values; the pin only shows them if firmware set its port data bit
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      port_zero_line_four_bypass_q  <= 1'b1;
      port_zero_line_five_bypass_q  <= 1'b1;
      port_zero_line_six_bypass_q   <= 1'b1;
      port_zero_line_seven_bypass_q <= 1'b1;
    end else begin
      // Select is only ever an input, so its bypass never leaves one
      port_zero_line_four_bypass_q  <= 1'b1;
      if (is_master) begin
        port_zero_line_five_bypass_q  <= shift_q[7];
        port_zero_line_six_bypass_q   <= 1'b1;
        port_zero_line_seven_bypass_q <= clock_polarity_bit_q ^ sck_act_q;
      end else if (is_slave) begin
        port_zero_line_five_bypass_q  <= 1'b1;
        port_zero_line_six_bypass_q   <= shift_q[7];
        port_zero_line_seven_bypass_q <= 1'b1;
      end else begin
        port_zero_line_five_bypass_q  <= 1'b1;
        port_zero_line_six_bypass_q   <= 1'b1;
        port_zero_line_seven_bypass_q <= 1'b1;
      end
    end
  end

endmodule // smsp_core

`default_nettype wire

// ===== smsp_core_props.sv
// Concurrent checks on the serial port register and pin ports
`timescale 1ns/1ps
`default_nettype none
module smsp_core_props #(
  parameter CLK_MHZ = 10
) (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic       spi_irq_q,
  // Bypass values
  input wire logic       port_zero_line_four_bypass_q,
  input wire logic       port_zero_line_five_bypass_q,
  input wire logic       port_zero_line_six_bypass_q,
  input wire logic       port_zero_line_seven_bypass_q
);
  logic [5:0] ctrl_q;
  logic       done_q;
  wire        wr_ctrl  = reg_wr && reg_addr == 8'h61;
  wire        done_now = done_q | spi_irq_q;
  // Reserved mode acts as disabled
  wire        off      = ctrl_q[5:4] == 2'b00 || ctrl_q[5:4] == 2'b11;
  wire        master   = ctrl_q[5:4] == 2'b01;
  wire        slave    = ctrl_q[5:4] == 2'b10;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= 6'h00;
      done_q <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_q <= reg_wdata[5:0];
      done_q <= done_now & ~(wr_ctrl & ~reg_wdata[7]);
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sel_bypass_a : assert property (port_zero_line_four_bypass_q)
    else $error("select bypass left one");
  off_pins_a : assert property (off && $past(off) |-> port_zero_line_five_bypass_q
    && port_zero_line_six_bypass_q && port_zero_line_seven_bypass_q) else $error("bypass low while off");
  master_in_a : assert property (master && $past(master) |-> port_zero_line_six_bypass_q)
    else $error("master input bypass low");
  slave_in_a : assert property (slave && $past(slave) |-> port_zero_line_five_bypass_q
    && port_zero_line_seven_bypass_q) else $error("slave input bypass low");
  rd_idle_a : assert property (!reg_rd |=> reg_rdata_q == 8'h00) else $error("read data not zero");
  unmap_rd_a : assert property (reg_rd && reg_addr[7:1] != 7'h30 |=> reg_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  ctrl_rd_a : assert property (reg_rd && reg_addr == 8'h61 |=> reg_rdata_q[7] == $past(done_now)
    && reg_rdata_q[5:0] == $past(ctrl_q)) else $error("control read wrong");
  irq_pulse_a : assert property (spi_irq_q |=> !spi_irq_q) else $error("interrupt too long");
  irq_mode_a : assert property (spi_irq_q |-> !off) else $error("interrupt while off");
endmodule // smsp_core_props
bind smsp_core smsp_core_props #(.CLK_MHZ(CLK_MHZ)) u_props (.*);
`default_nettype wire

// ===== smsp_slave_model.sv
// External SPI slave, clock idle low, sampling on the leading edge
`timescale 1ns/1ps
`default_nettype none
module smsp_slave_model (
  // Serial lines
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  output wire logic       miso,
  // Bytes
  input  wire logic [7:0] tx_byte,
  output var  logic [7:0] rx_byte
);
  logic [7:0] sh = 8'h00;
  // Released line shows the inverse, so a stale bit never matches
  assign miso = ss_n ? ~sh[7] : sh[7];
  // Select low loads the byte; each falling clock inside the frame shifts it
  always begin
    @(negedge ss_n);
    sh = tx_byte;
    while (!ss_n) begin
      @(negedge sck or posedge ss_n);
      if (!ss_n) sh = {sh[6:0], 1'b0};
    end
  end
  always @(posedge sck) if (!ss_n) rx_byte = {rx_byte[6:0], mosi};
endmodule // smsp_slave_model
`default_nettype wire

// ===== spi_master_slave_port_tb_top.sv
// Self-checking bench of the serial port
`timescale 1ns/1ps
`default_nettype none
`include "smsp_defs.vh"
module spi_master_slave_port_tb_top;
  logic       ref_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ss_n = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, tx_m = 8'h00;
  logic       port_zero_line_four_in = 1'b1, port_zero_line_five_in = 1'b0, port_zero_line_seven_in = 1'b0;
  wire  [7:0] reg_rdata_q, rx_m;
  wire        spi_irq_q, port_zero_line_six_in, port_zero_line_four_bypass_q, port_zero_line_five_bypass_q;
  wire        port_zero_line_six_bypass_q, port_zero_line_seven_bypass_q;
  // Port data bits are one and drive modes are set, so each pin shows its bypass
  wire        sk = port_zero_line_seven_bypass_q;
  int         error_cnt = 0, total_checks = 0, cyc = 0;
  // Clocks per bit at 100 ns a clock
  int         bc [4] = '{`SMSP_BIT_NS_0/100, `SMSP_BIT_NS_1/100, `SMSP_BIT_NS_2/100, `SMSP_BIT_NS_3/100};

  smsp_core #(.CLK_MHZ(`SMSP_CLK_MHZ)) dut (.*);
  smsp_slave_model u_slave (.sck(sk), .mosi(port_zero_line_five_bypass_q), .ss_n(ss_n),
    .miso(port_zero_line_six_in), .tx_byte(tx_m), .rx_byte(rx_m));

  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict;
    end
  end

  task automatic print_verdict;
    if (error_cnt == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk) reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rdc(input logic [7:0] a, e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk) reg_rd <= 1'b0;
    @(posedge ref_clk) chk(reg_rdata_q, e);
  endtask
  task automatic wirq(input int lim);
    for (int n = 0; n < lim && spi_irq_q !== 1'b1; n++) @(posedge ref_clk);
    chk({7'h00, spi_irq_q}, 8'h01);
  endtask
  task automatic t_off;
    rdc(8'h61, 8'h00);
    rdc(8'h60, 8'h00);
    rdc(8'h62, 8'h00);
    wr(8'h61, 8'hff);
    rdc(8'h61, 8'h3f);
    chk({4'h0, port_zero_line_four_bypass_q, port_zero_line_five_bypass_q, port_zero_line_six_bypass_q, sk}, 8'h0f);
  endtask
  task automatic t_clock_polarity_bit;
    wr(8'h61, 8'h18);
    repeat (3) @(posedge ref_clk);
    chk({7'h00, sk}, 8'h01);
  endtask
  task automatic xfer(input logic [1:0] r, input logic [7:0] d, s);
    int p = 0;
    wr(8'h61, {6'h04, r});
    rdc(8'h61, {6'h04, r});
    chk({7'h00, sk}, 8'h00);
    tx_m <= s;
    ss_n <= 1'b0;
    wr(8'h60, d);
    while (sk !== 1'b1) @(posedge ref_clk);
    while (sk === 1'b1) begin @(posedge ref_clk); p++; end
    while (sk !== 1'b1) begin @(posedge ref_clk); p++; end
    chk(p[7:0], bc[r][7:0]);
    wirq(2000);
    rdc(8'h60, s);
    rdc(8'h61, {6'h24, r});
    chk(rx_m, d);
    ss_n <= 1'b1;
  endtask
  task automatic t_tbf;
    ss_n <= 1'b0;
    wr(8'h60, 8'h11);
    wr(8'h60, 8'h22);
    wr(8'h60, 8'h33);
    rdc(8'h61, 8'hd3);
    wirq(3000);
    rdc(8'h61, 8'h93);
    wirq(3000);
    chk(rx_m, 8'h33);
    ss_n <= 1'b1;
  endtask
  // Far-side master, 800 ns link clock, still between frames
  task automatic sclk(input int nb, input logic [7:0] m, output logic [7:0] got);
    got = 8'h00;
    for (int i = 0; i < nb; i++) begin
      port_zero_line_five_in <= m[7-i];
      repeat (4) @(posedge ref_clk);
      port_zero_line_seven_in <= 1'b1;
      repeat (4) @(posedge ref_clk);
      got = {got[6:0], port_zero_line_six_bypass_q};
      port_zero_line_seven_in <= 1'b0;
    end
  endtask
  task automatic t_slave;
    logic [7:0] g;
    wr(8'h61, 8'h20);
    wr(8'h60, 8'h5a);
    port_zero_line_four_in <= 1'b0;
    repeat (8) @(posedge ref_clk);
    sclk(3, 8'hff, g);
    repeat (8) @(posedge ref_clk) port_zero_line_four_in <= 1'b1;
    rdc(8'h61, 8'h20);
    wr(8'h60, 8'h5a);
    port_zero_line_four_in <= 1'b0;
    repeat (8) @(posedge ref_clk);
    sclk(8, 8'h96, g);
    wirq(20);
    chk(g, 8'h5a);
    rdc(8'h60, 8'h96);
    port_zero_line_four_in <= 1'b1;
  endtask

  initial begin
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    t_off;
    t_clock_polarity_bit;
    for (int r = 0; r < 4; r++) xfer(r[1:0], {6'h29, r[1:0]}, {r[1:0], 6'h0e});
    t_tbf;
    t_slave;
    print_verdict;
  end
endmodule // spi_master_slave_port_tb_top
`default_nettype wire
